// ===== scan_select_pkg.sv
// Package for the input scan selection block: register layouts, reset values,
// selection codes. Assumes a host writes ten-bit control words over a parallel port.
package scan_select_pkg;

  localparam int REG_W = 10;
  localparam logic [1:0] ADDR_SETUP = 2'h0;
  localparam logic [1:0] ADDR_IFACE = 2'h1;

  // Setup register field positions
  localparam int CH_LO = 3;
  localparam int DIFF_LO = 5;
  localparam int SCAN_BIT = 7;
  localparam int TEST_LO = 8;

  // Interface register field positions
  localparam int RESET_BIT = 0;
  localparam int OVERFLOW_BIT = 1;
  localparam int FIFO_LEVEL_LO = 2;
  localparam int DATA_TYPE_BIT = 4;
  localparam int DATA_POL_BIT = 5;
  localparam int PIN_MODE_BIT = 6;
  localparam int FORMAT_BIT = 7;
  localparam int OFFSET_BIT = 8;
  localparam int READBACK_BIT = 9;

  localparam logic [9:0] SETUP_RESET = 10'h020;
  localparam logic [9:0] IFACE_RESET = 10'h030;

  // Conversion source codes
  typedef enum logic [2:0] {
    SRC_A_POS = 3'h0,
    SRC_A_NEG = 3'h1,
    SRC_B_POS = 3'h2,
    SRC_B_NEG = 3'h3,
    SRC_A_DIFF = 3'h4,
    SRC_B_DIFF = 3'h5,
    SRC_NONE = 3'h7
  } source_t;

  typedef enum logic [1:0] {
    TEST_NORMAL = 2'h0,
    TEST_UPPER = 2'h1,
    TEST_MID = 2'h2,
    TEST_LOWER = 2'h3
  } test_t;

  // One decoded selection: index of the last step and up to four steps
  typedef struct packed {
    logic [1:0] last_step;
    source_t step0;
    source_t step1;
    source_t step2;
    source_t step3;
    logic valid;
  } scan_plan_t;

  typedef struct packed {
    logic [9:0] setup;
    logic [9:0] iface;
  } regs_t;

endpackage

// ===== scan_plan_decode.sv
// Combinational decode of the scan, differential-count and channel fields
// into a sequence of conversion sources. Assumes package scan_select_pkg.
module scan_plan_decode (
  input wire logic scan,
  input wire logic [1:0] diffcount,
  input wire logic [1:0] channel_code,
  output scan_select_pkg::scan_plan_t plan
);
  always_comb begin
    plan = '{last_step: 2'h0, step0: scan_select_pkg::SRC_NONE,
             step1: scan_select_pkg::SRC_NONE, step2: scan_select_pkg::SRC_NONE,
             step3: scan_select_pkg::SRC_NONE, valid: 1'b0};
    case ({scan, diffcount, channel_code})
      5'h00, 5'h01, 5'h02, 5'h03: begin
        plan.step0 = scan_select_pkg::source_t'({1'b0, channel_code});
        plan.valid = 1'b1;
      end
      5'h04: begin
        plan.step0 = scan_select_pkg::SRC_A_DIFF;
        plan.valid = 1'b1;
      end
      5'h05: begin
        plan.step0 = scan_select_pkg::SRC_B_DIFF;
        plan.valid = 1'b1;
      end
      5'h11: begin
        plan = '{2'h1, scan_select_pkg::SRC_A_POS, scan_select_pkg::SRC_A_NEG,
                 scan_select_pkg::SRC_NONE, scan_select_pkg::SRC_NONE, 1'b1};
      end
      5'h12: begin
        plan = '{2'h2, scan_select_pkg::SRC_A_POS, scan_select_pkg::SRC_A_NEG,
                 scan_select_pkg::SRC_B_POS, scan_select_pkg::SRC_NONE, 1'b1};
      end
      5'h13: begin
        plan = '{2'h3, scan_select_pkg::SRC_A_POS, scan_select_pkg::SRC_A_NEG,
                 scan_select_pkg::SRC_B_POS, scan_select_pkg::SRC_B_NEG, 1'b1};
      end
      5'h15: begin
        plan = '{2'h1, scan_select_pkg::SRC_A_POS, scan_select_pkg::SRC_B_DIFF,
                 scan_select_pkg::SRC_NONE, scan_select_pkg::SRC_NONE, 1'b1};
      end
      5'h16: begin
        plan = '{2'h2, scan_select_pkg::SRC_A_POS, scan_select_pkg::SRC_A_NEG,
                 scan_select_pkg::SRC_B_DIFF, scan_select_pkg::SRC_NONE, 1'b1};
      end
      5'h19: begin
        plan = '{2'h1, scan_select_pkg::SRC_A_DIFF, scan_select_pkg::SRC_B_DIFF,
                 scan_select_pkg::SRC_NONE, scan_select_pkg::SRC_NONE, 1'b1};
      end
      default: begin
        // Reserved codes: no source, flagged invalid
        plan.valid = 1'b0;
      end
    endcase
  end
endmodule

// ===== adc_input_scan_select.sv
// Control register pair and input sequencer of a four-input sampling converter.
// Assumes a host writing ten-bit words with a register address, and a
// conversion strobe from the conversion clock logic, all on sys_clk.
//
// Summary of operation
// - The single-channel code is bits 3-4, the differential count bits 5-6 and scan bit 7.
// - A sequence is stepped only when scan selects more than one input, otherwise one source repeats.
// - With all scan and differential bits zero the channel code picks A+, A-, B+ or B- single ended.
// - Differential count 01 without scan converts the A pair for code 00 and B pair for code 01.
// - Scan with channel 01 alternates A+ and A-.
// - Scan with channel 10 cycles A+, A-, B+.
// - Scan with channel 11 cycles A+, A-, B+, B-.
// - Scan, differential count 01, channel 01 alternates A+ and the B pair.
// - Scan, differential count 01, channel 10 cycles A+, A- and the B pair.
// - Scan, differential count 10, channel 01 alternates the A pair and the B pair.
// - Test bits 8-9 select normal, upper reference, reference midpoint or lower reference.
// - The second register holds reset, overflow/fifo clear, level, data type, polarity, pin mode, format, offset and readback bits.
// - After reset the A pair difference is converted in normal mode.
module adc_input_scan_select (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_strobe,
  input wire logic [1:0] wr_addr,
  input wire logic [9:0] wr_data,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_addr,
  input wire logic conv_strobe,
  input wire logic fifo_overflow,
  output logic [9:0] rd_data,
  output scan_select_pkg::source_t conv_source,
  output scan_select_pkg::test_t test_select,
  output logic selection_valid,
  output logic fifo_clear,
  output logic device_reset,
  output logic [1:0] fifo_level,
  output logic data_av_pulse,
  output logic data_av_active_high,
  output logic rw_pin_mode,
  output logic output_number_format,
  output logic offset_calibration,
  output logic register_readback
);

  typedef struct packed {
    scan_select_pkg::regs_t regs;
    logic [1:0] step;
    logic overflow;
    logic fifo_clear;
    logic dev_reset;
    logic [9:0] rd_data;
    scan_select_pkg::source_t src;
  } state_t;

  state_t q, d;
  // Every selection starts on, and single selections stay on, the first step
  localparam logic [1:0] FIRST_STEP = 2'h0;

  scan_select_pkg::scan_plan_t plan;
  scan_select_pkg::scan_plan_t plan_wr;
  logic wr_setup;
  logic wr_iface;
  logic rd_iface;
  logic step_wrap;
  logic [1:0] step_next;
  logic [9:0] iface_wr;
  logic [9:0] iface_rd;
  logic scan;
  logic [1:0] diffcount;
  logic [1:0] channel_code;

  assign channel_code = q.regs.setup[scan_select_pkg::CH_LO +: 2];
  assign diffcount = q.regs.setup[scan_select_pkg::DIFF_LO +: 2];
  assign scan = q.regs.setup[scan_select_pkg::SCAN_BIT];

  scan_plan_decode u_decode (
    .scan(scan),
    .diffcount(diffcount),
    .channel_code(channel_code),
    .plan(plan)
  );

  // The incoming word is decoded as well, so a new selection shows its first
  // source in the same cycle as the register itself
  scan_plan_decode u_decode_wr (
    .scan(wr_data[scan_select_pkg::SCAN_BIT]),
    .diffcount(wr_data[scan_select_pkg::DIFF_LO +: 2]),
    .channel_code(wr_data[scan_select_pkg::CH_LO +: 2]),
    .plan(plan_wr)
  );

  function automatic scan_select_pkg::source_t pick(
    input scan_select_pkg::scan_plan_t p, input logic [1:0] s);
    case (s)
      2'h0: begin
        pick = p.step0;
      end
      2'h1: begin
        pick = p.step1;
      end
      2'h2: begin
        pick = p.step2;
      end
      default: begin
        pick = p.step3;
      end
    endcase
  endfunction

  // Address decode of the two host strobes; reserved addresses match neither
  assign wr_setup = wr_strobe && (wr_addr == scan_select_pkg::ADDR_SETUP);
  assign wr_iface = wr_strobe && (wr_addr == scan_select_pkg::ADDR_IFACE);
  assign rd_iface = rd_strobe && (rd_addr == scan_select_pkg::ADDR_IFACE);

  // Single and reserved selections never leave the first step
  assign step_wrap = !plan.valid || (q.step >= plan.last_step);
  assign step_next = step_wrap ? FIRST_STEP : q.step + 2'h1;

  // Bits 0 and 1 are commands, not storage, so they are never kept
  always_comb begin
    iface_wr = wr_data;
    iface_wr[scan_select_pkg::RESET_BIT] = 1'b0;
    iface_wr[scan_select_pkg::OVERFLOW_BIT] = 1'b0;
  end

  // Readback shows the overflow flag in place of the fifo clear command
  always_comb begin
    iface_rd = q.regs.iface;
    iface_rd[scan_select_pkg::OVERFLOW_BIT] = q.overflow;
    iface_rd[scan_select_pkg::RESET_BIT] = 1'b0;
  end

  always_comb begin
    d = q;
    d.fifo_clear = 1'b0;
    d.dev_reset = 1'b0;
    // Overflow flag: a new overflow wins over the clear-on-read
    if (rd_iface) begin
      d.overflow = 1'b0;
    end
    if (fifo_overflow) begin
      d.overflow = 1'b1;
    end
    // Read data is captured once and held until the next read
    if (rd_strobe) begin
      case (rd_addr)
        scan_select_pkg::ADDR_SETUP: begin
          d.rd_data = q.regs.setup;
        end
        scan_select_pkg::ADDR_IFACE: begin
          d.rd_data = iface_rd;
        end
        default: begin
          d.rd_data = 10'h000;
        end
      endcase
    end
    // Sequencer advances once per conversion
    if (conv_strobe) begin
      d.step = step_next;
      d.src = pick(plan, step_next);
    end else if (q.step == FIRST_STEP) begin
      d.src = pick(plan, FIRST_STEP);
    end
    // A setup write wins over a conversion in the same cycle and restarts the sequence
    if (wr_setup) begin
      d.regs.setup = wr_data;
      d.step = FIRST_STEP;
      d.src = pick(plan_wr, FIRST_STEP);
    end
    if (wr_iface) begin
      d.regs.iface = iface_wr;
      d.fifo_clear = wr_data[scan_select_pkg::OVERFLOW_BIT];
      if (wr_data[scan_select_pkg::RESET_BIT]) begin
        // Self-reset restores both registers and the sequence
        d.regs.setup = scan_select_pkg::SETUP_RESET;
        d.regs.iface = scan_select_pkg::IFACE_RESET;
        d.step = FIRST_STEP;
        d.src = scan_select_pkg::SRC_A_DIFF;
        d.overflow = 1'b0;
        d.dev_reset = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q.regs.setup <= scan_select_pkg::SETUP_RESET;
      q.regs.iface <= scan_select_pkg::IFACE_RESET;
      q.step <= 2'h0;
      q.overflow <= 1'b0;
      q.fifo_clear <= 1'b0;
      q.dev_reset <= 1'b0;
      q.rd_data <= 10'h000;
      q.src <= scan_select_pkg::SRC_A_DIFF;
    end else begin
      q <= d;
    end
  end

  // Read data and sequence source come straight from flip-flops
  assign rd_data = q.rd_data;
  assign conv_source = q.src;
  // Setup fields seen by the converter core
  assign test_select = scan_select_pkg::test_t'(q.regs.setup[scan_select_pkg::TEST_LO +: 2]);
  assign selection_valid = plan.valid;
  // Command pulses last exactly one cycle
  assign fifo_clear = q.fifo_clear;
  assign device_reset = q.dev_reset;
  // Interface fields, straight from storage
  assign fifo_level = q.regs.iface[scan_select_pkg::FIFO_LEVEL_LO +: 2];
  assign data_av_pulse = q.regs.iface[scan_select_pkg::DATA_TYPE_BIT];
  assign data_av_active_high = q.regs.iface[scan_select_pkg::DATA_POL_BIT];
  assign rw_pin_mode = q.regs.iface[scan_select_pkg::PIN_MODE_BIT];
  assign output_number_format = q.regs.iface[scan_select_pkg::FORMAT_BIT];
  assign offset_calibration = q.regs.iface[scan_select_pkg::OFFSET_BIT];
  assign register_readback = q.regs.iface[scan_select_pkg::READBACK_BIT];

endmodule

// ===== scan_select_sva.sv
// Checker for the scan selection block: register outputs and the source set by a setup write.
// Assumes it is bound to adc_input_scan_select and sees only its ports.
module scan_select_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_strobe,
  input wire logic [1:0] wr_addr,
  input wire logic [9:0] wr_data,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_addr,
  input wire logic [9:0] rd_data,
  input wire scan_select_pkg::source_t conv_source,
  input wire scan_select_pkg::test_t test_select,
  input wire logic selection_valid,
  input wire logic fifo_clear,
  input wire logic device_reset,
  input wire logic [1:0] fifo_level,
  input wire logic data_av_pulse,
  input wire logic data_av_active_high,
  input wire logic rw_pin_mode,
  input wire logic output_number_format,
  input wire logic offset_calibration,
  input wire logic register_readback
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic w0;
  logic w1;
  assign w0 = wr_strobe && wr_addr == 2'h0;
  assign w1 = wr_strobe && wr_addr == 2'h1;
  test_follow_a: assert property (w0 |=> test_select == $past(wr_data[9:8]))
    else $error("test select not taken");
  single_src_a: assert property (w0 && wr_data[7:5] == 3'h0
    |=> conv_source == {1'b0, $past(wr_data[4:3])}) else $error("single source wrong");
  diff_src_a: assert property (w0 && wr_data[7:4] == 4'h2
    |=> conv_source == ($past(wr_data[3]) ? 3'h5 : 3'h4)) else $error("pair source wrong");
  scan_start_a: assert property (w0 && wr_data[7] && wr_data[6:3] inside {4'h1, 4'h2, 4'h3,
    4'h5, 4'h6} |=> conv_source == 3'h0) else $error("scan start wrong");
  reserved_sel_a: assert property (w0 && wr_data[7:3] == 5'h10
    |=> !selection_valid && conv_source == 3'h7) else $error("reserved code accepted");
  iface_bits_a: assert property (w1 && !wr_data[0] |=> {register_readback, offset_calibration,
    output_number_format, rw_pin_mode, data_av_active_high, data_av_pulse, fifo_level}
    == $past(wr_data[9:2])) else $error("interface bits wrong");
  clear_pulse_a: assert property (fifo_clear == $past(w1 && wr_data[1]))
    else $error("fifo clear pulse wrong");
  reset_pulse_a: assert property (device_reset == $past(w1 && wr_data[0]))
    else $error("device reset pulse wrong");
  unmapped_rd_a: assert property (rd_strobe && rd_addr[1] |=> rd_data == 10'h000)
    else $error("unmapped read not zero");
  reset_vals_a: assert property ($fell(rst) |-> conv_source == 3'h4 && test_select == 2'h0)
    else $error("reset selection wrong");
endmodule
bind adc_input_scan_select scan_select_sva i_sva (.*);

// ===== host_model.sv
// Host processor model: one register write or read at a time on the parallel port.
// Assumes sys_clk only; each request is raised after an edge and held one cycle.
module host_model (
  input wire logic sys_clk,
  output logic wr_strobe,
  output logic [1:0] wr_addr,
  output logic [9:0] wr_data,
  output logic rd_strobe,
  output logic [1:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address and data stay unknown until the first request; the strobes qualify them
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [1:0] a, input logic [9:0] d);
    @(posedge sys_clk);
    wr_strobe <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    rd_strobe <= 1'b1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    rd_addr <= ~a;
  endtask
endmodule

// ===== testbench.sv
// Bench for the scan selection block: selections, test codes, interface register.
// Assumes host_model drives the register port; expected results queue up for a monitor.
`define chk(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, conv_strobe = 0, fifo_overflow = 0, rd_seen = 0, src_seen = 0;
  logic wr_strobe, rd_strobe, selection_valid, fifo_clear, device_reset, data_av_pulse;
  logic data_av_active_high, rw_pin_mode, output_number_format, offset_calibration;
  logic register_readback;
  logic [1:0] wr_addr, rd_addr, fifo_level, idx;
  logic [9:0] wr_data, rd_data, wd, e_rd;
  scan_select_pkg::source_t conv_source, e_src;
  scan_select_pkg::test_t test_select;
  logic [9:0] exp_rd[$];
  scan_select_pkg::source_t exp_src[$];
  int failures = 0, total_checks = 0, cycles = 0;
  int seed = 32'h5681dbd8;
  // Entry: selection code, last step, four 3-bit sources; the last code is reserved
  logic [18:0] sel [13] = '{19'h00000, 19'h04200, 19'h08400, 19'h0c600, 19'h10800,
    19'h14a00, 19'h45040, 19'h4a050, 19'h4f053, 19'h55140, 19'h5a068, 19'h65940,
    19'h40fff};
  host_model i_host (.sys_clk(sys_clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
  adc_input_scan_select i_dut (.sys_clk(sys_clk), .rst(rst), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .conv_strobe(conv_strobe), .fifo_overflow(fifo_overflow), .rd_data(rd_data),
    .conv_source(conv_source), .test_select(test_select), .selection_valid(selection_valid),
    .fifo_clear(fifo_clear), .device_reset(device_reset), .fifo_level(fifo_level),
    .data_av_pulse(data_av_pulse), .data_av_active_high(data_av_active_high),
    .rw_pin_mode(rw_pin_mode), .output_number_format(output_number_format),
    .offset_calibration(offset_calibration), .register_readback(register_readback));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse_conv(input int i);
    exp_src.push_back(scan_select_pkg::source_t'(sel[i][11 - 3 * idx -: 3]));
    @(posedge sys_clk) conv_strobe <= 1'b1;
    @(posedge sys_clk) conv_strobe <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    rd_seen <= rd_strobe;
    src_seen <= conv_strobe | (wr_strobe && wr_addr == 2'h0);
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      e_rd = exp_rd.pop_front();
      `chk("rd_data", e_rd, rd_data)
    end
    if (src_seen) begin
      e_src = exp_src.pop_front();
      `chk("conv_source", e_src, conv_source)
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `chk("reset_source", scan_select_pkg::SRC_A_DIFF, conv_source)
    exp_rd.push_back(scan_select_pkg::SETUP_RESET);
    i_host.rd(2'h0);
    exp_rd.push_back(scan_select_pkg::IFACE_RESET);
    i_host.rd(2'h1);
    foreach (sel[i]) begin
      wd = {2'($random(seed)), sel[i][18:14], 3'($random(seed))};
      idx = 2'h0;
      i_host.wr(2'h0, wd);
      exp_src.push_back(scan_select_pkg::source_t'(sel[i][11:9]));
      #1;
      `chk("test_select", wd[9:8], test_select)
      `chk("valid", sel[i][11:0] != 12'hfff, selection_valid)
      exp_rd.push_back(wd);
      i_host.rd(2'h0);
      repeat (5) begin
        idx = (idx == sel[i][13:12]) ? 2'h0 : idx + 2'h1;
        pulse_conv(i);
      end
    end
    wd = 10'($random(seed)) & 10'h3fc;
    i_host.wr(2'h1, wd);
    #1;
    `chk("iface", wd[9:2], {register_readback, offset_calibration, output_number_format, rw_pin_mode, data_av_active_high, data_av_pulse, fifo_level})
    @(posedge sys_clk) fifo_overflow <= 1'b1;
    @(posedge sys_clk) fifo_overflow <= 1'b0;
    exp_rd.push_back(wd | 10'h002);
    i_host.rd(2'h1);
    exp_rd.push_back(wd);
    i_host.rd(2'h1);
    exp_rd.push_back(wd);
    fork
      i_host.rd(2'h1);
      begin
        @(posedge sys_clk) fifo_overflow <= 1'b1;
        @(posedge sys_clk) fifo_overflow <= 1'b0;
      end
    join
    exp_rd.push_back(wd | 10'h002);
    i_host.rd(2'h1);
    i_host.wr(2'h1, wd | 10'h002);
    #1;
    `chk("fifo_clear", 1'b1, fifo_clear)
    i_host.wr(2'h1, 10'h001);
    #1;
    `chk("device_reset", 1'b1, device_reset)
    `chk("reset_source", scan_select_pkg::SRC_A_DIFF, conv_source)
    exp_rd.push_back(scan_select_pkg::SETUP_RESET);
    i_host.rd(2'h0);
    i_host.wr(2'h2, 10'h3ff);
    exp_rd.push_back(10'h000);
    i_host.rd(2'h2);
    repeat (2) @(posedge sys_clk);
    report_and_stop;
  end
endmodule
